// ---- logic/fcl_pkg.sv ----
`default_nettype none
package fcl_pkg;

    // system clock and millisecond base for the start-up delay
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // fuse byte offsets inside the fuse section
    localparam logic [7:0] OFS_OSC = 8'h02;
    localparam logic [7:0] OFS_SYSA = 8'h05;
    localparam logic [7:0] OFS_SYSB = 8'h06;
    localparam logic [7:0] OFS_CODE = 8'h07;
    localparam logic [7:0] OFS_BOOT = 8'h08;

    // shadow slots, loaded in this order
    localparam int NUM_FUSE = 5;
    localparam logic [2:0] IDX_OSC = 3'h0;
    localparam logic [2:0] IDX_SYSA = 3'h1;
    localparam logic [2:0] IDX_SYSB = 3'h2;
    localparam logic [2:0] IDX_CODE = 3'h3;
    localparam logic [2:0] IDX_BOOT = 3'h4;

    // factory defaults, held in the shadow until the fuse load overwrites them
    localparam logic [7:0] DEF_OSC = 8'h00;
    localparam logic [7:0] DEF_SYSA = 8'hC0;
    localparam logic [7:0] DEF_SYSB = 8'h08;
    localparam logic [7:0] DEF_CODE = 8'h00;
    localparam logic [7:0] DEF_BOOT = 8'h00;

    // field positions and codes
    localparam int CLKSRC_MSB = 3;
    localparam int CLKSRC_LSB = 0;
    localparam logic [3:0] CLK_FAST = 4'h0;
    localparam logic [3:0] CLK_SLOW = 4'h1;
    localparam int SCAN_MSB = 7;
    localparam int SCAN_LSB = 6;
    localparam logic [1:0] SCAN_OFF = 2'h3;
    localparam int SCAN_POLY_BIT = 5;
    localparam int RSTPIN_BIT = 3;
    localparam int EE_RETAIN_BIT = 0;
    localparam int SUPPLY_MSB = 4;
    localparam int SUPPLY_LSB = 3;
    localparam logic [1:0] SUPPLY_DUAL = 2'h1;
    localparam logic [1:0] SUPPLY_SINGLE = 2'h2;
    localparam int DLY_MSB = 2;
    localparam int DLY_LSB = 0;
    localparam logic [7:0] BOOT_WHOLE_FLASH = 8'h00;

    // lock key and the byte returned by a blocked read
    localparam logic [31:0] KEY_UNLOCK = 32'h5CC5C55C;
    localparam logic [7:0] READ_INVALID = 8'hFF;

    // memory sections seen by the access guard
    localparam logic [2:0] SECT_FLASH = 3'h0;
    localparam logic [2:0] SECT_SRAM = 3'h1;
    localparam logic [2:0] SECT_EEPROM = 3'h2;
    localparam logic [2:0] SECT_USER_ROW = 3'h3;
    localparam logic [2:0] SECT_SIG_ROW = 3'h4;
    localparam logic [2:0] SECT_FUSE = 3'h5;
    localparam logic [2:0] SECT_LOCK = 3'h6;
    localparam logic [2:0] SECT_REGS = 3'h7;

endpackage
`default_nettype wire

// ---- logic/fcl_startup_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module fcl_startup_timer
    import fcl_pkg::*;
#(
    parameter int CYC_PER_MS = MS_CYCLES
) (
    input wire logic clk_i,        // system clock
    input wire logic sys_rst_i,    // async reset, active high
    input wire logic start_i,      // one-cycle start pulse
    input wire logic [2:0] code_i, // start-up delay code
    output logic done_o            // level, high once delay elapsed
);
    localparam int PW = $clog2(CYC_PER_MS);

    typedef struct packed {
        logic busy;
        logic done;
        logic [PW-1:0] pre;
        logic [6:0] ms;
        logic [6:0] target;
    } fcl_tmr_t;

    fcl_tmr_t q;
    fcl_tmr_t next_q;
    logic tick;

    // millisecond enable from the prescaler
    assign tick = (q.pre == PW'(CYC_PER_MS - 1));

    // code 0 finishes at once, code n waits 2^(n-1) ms
    always_comb begin
        next_q = q;
        if (start_i) begin
            next_q.busy = (code_i != 3'h0);
            next_q.done = (code_i == 3'h0);
            next_q.pre = '0;
            next_q.ms = 7'h00;
            next_q.target = 7'h01 << (code_i - 3'h1);
        end else if (q.busy) begin
            next_q.pre = tick ? '0 : q.pre + 1'b1;
            if (tick) begin
                next_q.ms = q.ms + 7'h01;
                if (q.ms + 7'h01 == q.target) begin
                    next_q.busy = 1'b0;
                    next_q.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign done_o = q.done;
endmodule
`default_nettype wire

// ---- logic/fcl_guard.sv ----
`timescale 1ns/100ps
`default_nettype none
module fcl_guard
    import fcl_pkg::*;
#(
    parameter int CYC_PER_MS = MS_CYCLES
) (
    input wire logic clk_i,              // system clock, 100 MHz
    input wire logic sys_rst_i,          // async reset, active high
    // nonvolatile / memory side
    output logic mem_req_o,              // access request, held to ack
    output logic mem_we_o,               // 1 write, 0 read
    output logic [2:0] mem_sect_o,       // target section
    output logic [15:0] mem_addr_o,      // address in section
    output logic [7:0] mem_wdata_o,      // write byte
    input wire logic mem_ack_i,          // one-cycle completion
    input wire logic [7:0] mem_rdata_i,  // read byte, valid with ack
    input wire logic [31:0] lock_key_i,  // stored lock key
    // cpu port
    input wire logic cpu_req_i,          // request, held until ack
    input wire logic cpu_we_i,           // 1 write
    input wire logic [2:0] cpu_sect_i,   // section
    input wire logic [15:0] cpu_addr_i,  // address
    input wire logic [7:0] cpu_wdata_i,  // write byte
    output logic cpu_ack_o,              // completion pulse
    output logic [7:0] cpu_rdata_o,      // read byte
    output logic cpu_denied_o,           // write refused, with ack
    // debug/programming port
    input wire logic dbg_req_i,          // request, held until ack
    input wire logic dbg_we_i,           // 1 write
    input wire logic [2:0] dbg_sect_i,   // section
    input wire logic [15:0] dbg_addr_i,  // address
    input wire logic [7:0] dbg_wdata_i,  // write byte
    input wire logic dbg_erase_i,        // chip erase, held until ack
    output logic dbg_ack_o,              // completion pulse
    output logic [7:0] dbg_rdata_o,      // read byte
    output logic dbg_denied_o,           // write refused, with ack
    output logic erase_o,                // chip erase start pulse
    output logic erase_eeprom_o,         // erase includes the EEPROM
    input wire logic erase_done_i,       // erase finished pulse
    // decoded configuration
    output logic osc_slow_o,             // slow oscillator selected
    output logic osc_reserved_o,         // clock source code reserved
    output logic [1:0] scan_region_o,    // scan region code
    output logic scan_enable_o,          // start-up scan wanted
    output logic scan_crc32_o,           // 1 CRC-32, 0 CRC-16
    output logic rst_pin_reset_o,        // pin is reset with pull-up
    output logic supply_dual_o,          // dual supply mode
    output logic supply_reserved_o,      // supply code reserved
    output logic [7:0] code_blocks_o,    // boot+app size, 512 B units
    output logic [7:0] boot_blocks_o,    // boot size, 512 B units
    output logic boot_whole_flash_o,     // whole flash is boot
    output logic cfg_valid_o,            // config loaded, cpu may run
    output logic locked_o                // debug access locked
);
    typedef enum logic [4:0] {
        ST_LOAD = 5'h01,
        ST_DELAY = 5'h02,
        ST_IDLE = 5'h04,
        ST_MEM = 5'h08,
        ST_ERASE = 5'h10
    } fcl_state_t;

    typedef struct packed {
        fcl_state_t st;
        logic [2:0] idx;
        logic [NUM_FUSE-1:0][7:0] raw;
        logic tmr_start;
        logic who_dbg;
        logic mem_req;
        logic mem_we;
        logic [2:0] mem_sect;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic cpu_ack;
        logic [7:0] cpu_rdata;
        logic cpu_denied;
        logic dbg_ack;
        logic [7:0] dbg_rdata;
        logic dbg_denied;
        logic erase;
        logic erase_ee;
        logic osc_slow;
        logic osc_res;
        logic [1:0] scan_region;
        logic scan_en;
        logic scan_crc32;
        logic rst_pin;
        logic sup_dual;
        logic sup_res;
        logic [7:0] code_blk;
        logic [7:0] boot_blk;
        logic boot_all;
        logic run;
        logic locked;
    } fcl_state_all_t;

    fcl_state_all_t q;
    fcl_state_all_t next_q;
    logic tmr_done;
    logic key_locked;

    // shadow slot to fuse offset
    function automatic logic [7:0] fuse_ofs(input logic [2:0] i);
        case (i)
            IDX_OSC: fuse_ofs = OFS_OSC;
            IDX_SYSA: fuse_ofs = OFS_SYSA;
            IDX_SYSB: fuse_ofs = OFS_SYSB;
            IDX_CODE: fuse_ofs = OFS_CODE;
            default: fuse_ofs = OFS_BOOT;
        endcase
    endfunction

    // who may do what, per port and lock state
    function automatic logic access_ok(input logic dbg, input logic we,
                                       input logic [2:0] sect,
                                       input logic lck);
        logic prot;
        prot = (sect == SECT_SIG_ROW) || (sect == SECT_FUSE) ||
               (sect == SECT_LOCK);
        if (!dbg) begin
            access_ok = !(we && prot);
        end else if (lck) begin
            access_ok = we && (sect == SECT_USER_ROW);
        end else begin
            access_ok = !(we && (sect == SECT_SIG_ROW));
        end
    endfunction

    // key compared live, so a finished erase unlocks next cycle
    assign key_locked = (lock_key_i != KEY_UNLOCK);

    fcl_startup_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(q.tmr_start),
        .code_i(q.raw[IDX_SYSB][DLY_MSB:DLY_LSB]),
        .done_o(tmr_done)
    );

    // sequencer: fuse load, start-up delay, then guarded accesses
    always_comb begin
        next_q = q;
        next_q.tmr_start = 1'b0;
        next_q.cpu_ack = 1'b0;
        next_q.cpu_denied = 1'b0;
        next_q.dbg_ack = 1'b0;
        next_q.dbg_denied = 1'b0;
        next_q.erase = 1'b0;
        next_q.locked = key_locked;
        case (q.st)
            ST_LOAD: begin
                // req drops a cycle between bytes so addr never slides
                if (q.mem_req && mem_ack_i) begin
                    next_q.raw[q.idx] = mem_rdata_i;
                    next_q.mem_req = 1'b0;
                    if (q.idx == IDX_BOOT) begin
                        next_q.st = ST_DELAY;
                        next_q.tmr_start = 1'b1;
                    end else begin
                        next_q.idx = q.idx + 3'h1;
                    end
                end else begin
                    next_q.mem_req = 1'b1;
                    next_q.mem_we = 1'b0;
                    next_q.mem_sect = SECT_FUSE;
                    next_q.mem_addr = {8'h00, fuse_ofs(q.idx)};
                end
            end
            ST_DELAY: begin
                // fuses only reach the outputs here, once per reset
                if (tmr_done) begin
                    next_q.osc_slow =
                        q.raw[IDX_OSC][CLKSRC_MSB:CLKSRC_LSB] == CLK_SLOW;
                    next_q.osc_res =
                        (q.raw[IDX_OSC][CLKSRC_MSB:CLKSRC_LSB] != CLK_SLOW)
                        && (q.raw[IDX_OSC][CLKSRC_MSB:CLKSRC_LSB]
                            != CLK_FAST);
                    next_q.scan_region =
                        q.raw[IDX_SYSA][SCAN_MSB:SCAN_LSB];
                    next_q.scan_en =
                        q.raw[IDX_SYSA][SCAN_MSB:SCAN_LSB] != SCAN_OFF;
                    next_q.scan_crc32 =
                        q.raw[IDX_SYSA][SCAN_POLY_BIT];
                    next_q.rst_pin = q.raw[IDX_SYSA][RSTPIN_BIT];
                    next_q.erase_ee =
                        !q.raw[IDX_SYSA][EE_RETAIN_BIT];
                    next_q.sup_dual =
                        q.raw[IDX_SYSB][SUPPLY_MSB:SUPPLY_LSB]
                        == SUPPLY_DUAL;
                    next_q.sup_res =
                        (q.raw[IDX_SYSB][SUPPLY_MSB:SUPPLY_LSB]
                         != SUPPLY_DUAL) &&
                        (q.raw[IDX_SYSB][SUPPLY_MSB:SUPPLY_LSB]
                         != SUPPLY_SINGLE);
                    next_q.boot_blk = q.raw[IDX_BOOT];
                    next_q.boot_all =
                        q.raw[IDX_BOOT] == BOOT_WHOLE_FLASH;
                    // code size unused when boot spans the whole flash
                    next_q.code_blk =
                        (q.raw[IDX_BOOT] == BOOT_WHOLE_FLASH) ?
                        8'h00 : q.raw[IDX_CODE];
                    next_q.run = 1'b1;
                    next_q.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // debug first; a port whose ack is out is not retaken
                if (dbg_erase_i && !q.dbg_ack) begin
                    next_q.erase = 1'b1;
                    next_q.st = ST_ERASE;
                end else if (dbg_req_i && !q.dbg_ack) begin
                    next_q.who_dbg = 1'b1;
                    if (access_ok(1'b1, dbg_we_i, dbg_sect_i,
                                  key_locked)) begin
                        next_q.mem_req = 1'b1;
                        next_q.mem_we = dbg_we_i;
                        next_q.mem_sect = dbg_sect_i;
                        next_q.mem_addr = dbg_addr_i;
                        next_q.mem_wdata = dbg_wdata_i;
                        next_q.st = ST_MEM;
                    end else begin
                        // no error on a blocked read, only junk data
                        next_q.dbg_ack = 1'b1;
                        next_q.dbg_rdata = READ_INVALID;
                        next_q.dbg_denied = dbg_we_i;
                    end
                end else if (cpu_req_i && !q.cpu_ack) begin
                    next_q.who_dbg = 1'b0;
                    if (access_ok(1'b0, cpu_we_i, cpu_sect_i,
                                  key_locked)) begin
                        next_q.mem_req = 1'b1;
                        next_q.mem_we = cpu_we_i;
                        next_q.mem_sect = cpu_sect_i;
                        next_q.mem_addr = cpu_addr_i;
                        next_q.mem_wdata = cpu_wdata_i;
                        next_q.st = ST_MEM;
                    end else begin
                        next_q.cpu_ack = 1'b1;
                        next_q.cpu_rdata = READ_INVALID;
                        next_q.cpu_denied = 1'b1;
                    end
                end
            end
            ST_MEM: begin
                if (mem_ack_i) begin
                    next_q.mem_req = 1'b0;
                    next_q.st = ST_IDLE;
                    if (q.who_dbg) begin
                        next_q.dbg_ack = 1'b1;
                        next_q.dbg_rdata = mem_rdata_i;
                    end else begin
                        next_q.cpu_ack = 1'b1;
                        next_q.cpu_rdata = mem_rdata_i;
                    end
                end
            end
            ST_ERASE: begin
                // the lock clears through the restored key, not here
                if (erase_done_i) begin
                    next_q.dbg_ack = 1'b1;
                    next_q.st = ST_IDLE;
                end
            end
            default: begin
                next_q.st = ST_LOAD;
            end
        endcase
    end

    // reset loads factory defaults into the shadow and shows a locked debug port
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.st <= ST_LOAD;
            q.raw[IDX_OSC] <= DEF_OSC;
            q.raw[IDX_SYSA] <= DEF_SYSA;
            q.raw[IDX_SYSB] <= DEF_SYSB;
            q.raw[IDX_CODE] <= DEF_CODE;
            q.raw[IDX_BOOT] <= DEF_BOOT;
            q.scan_region <= SCAN_OFF;
            q.boot_all <= 1'b1;
            q.locked <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign mem_req_o = q.mem_req;
    assign mem_we_o = q.mem_we;
    assign mem_sect_o = q.mem_sect;
    assign mem_addr_o = q.mem_addr;
    assign mem_wdata_o = q.mem_wdata;
    assign cpu_ack_o = q.cpu_ack;
    assign cpu_rdata_o = q.cpu_rdata;
    assign cpu_denied_o = q.cpu_denied;
    assign dbg_ack_o = q.dbg_ack;
    assign dbg_rdata_o = q.dbg_rdata;
    assign dbg_denied_o = q.dbg_denied;
    assign erase_o = q.erase;
    assign erase_eeprom_o = q.erase_ee;
    assign osc_slow_o = q.osc_slow;
    assign osc_reserved_o = q.osc_res;
    assign scan_region_o = q.scan_region;
    assign scan_enable_o = q.scan_en;
    assign scan_crc32_o = q.scan_crc32;
    assign rst_pin_reset_o = q.rst_pin;
    assign supply_dual_o = q.sup_dual;
    assign supply_reserved_o = q.sup_res;
    assign code_blocks_o = q.code_blk;
    assign boot_blocks_o = q.boot_blk;
    assign boot_whole_flash_o = q.boot_all;
    assign cfg_valid_o = q.run;
    assign locked_o = q.locked;
endmodule
`default_nettype wire

// ---- bench/fcl_guard_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module fcl_guard_props
    import fcl_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic mem_req_o, // mem request
    input wire logic mem_we_o, // mem write
    input wire logic [2:0] mem_sect_o, // mem section
    input wire logic [15:0] mem_addr_o, // mem address
    input wire logic mem_ack_i, // mem done
    input wire logic cpu_we_i, // cpu write
    input wire logic [2:0] cpu_sect_i, // cpu section
    input wire logic cpu_ack_o, // cpu done
    input wire logic [7:0] cpu_rdata_o, // cpu data
    input wire logic cpu_denied_o, // cpu refused
    input wire logic dbg_we_i, // debug write
    input wire logic [2:0] dbg_sect_i, // debug section
    input wire logic dbg_erase_i, // erase command
    input wire logic dbg_ack_o, // debug done
    input wire logic [7:0] dbg_rdata_o, // debug data
    input wire logic dbg_denied_o, // debug refused
    input wire logic erase_o, // erase start
    input wire logic erase_done_i, // erase end
    input wire logic [1:0] scan_region_o, // scan region
    input wire logic [7:0] code_blocks_o, // code size
    input wire logic [7:0] boot_blocks_o, // boot size
    input wire logic boot_whole_flash_o, // whole flash boot
    input wire logic cfg_valid_o, // config loaded
    input wire logic locked_o // lock state
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // the lock must be settled over the whole access to judge it
    chk_load_first: assert property (
        $fell(sys_rst_i) |=> mem_req_o && mem_sect_o == SECT_FUSE
        && mem_addr_o == 16'h0002) else $error("fuse load start wrong");
    chk_sig_nowrite: assert property (
        mem_req_o && mem_we_o |-> mem_sect_o != SECT_SIG_ROW)
        else $error("signature row written");
    chk_cpu_refuse: assert property (
        cpu_ack_o && !$past(mem_ack_i) |-> cpu_denied_o
        && cpu_rdata_o == READ_INVALID) else $error("cpu refusal wrong");
    chk_cpu_why: assert property (
        cpu_denied_o |-> cpu_we_i && cpu_sect_i inside {3'h4, 3'h5, 3'h6})
        else $error("cpu refused without cause");
    chk_lock_read: assert property (
        dbg_ack_o && !dbg_we_i && !dbg_erase_i && locked_o
        && $past(locked_o) && $past(locked_o, 2)
        |-> dbg_rdata_o == READ_INVALID && !dbg_denied_o)
        else $error("locked read leaked data");
    chk_lock_write: assert property (
        dbg_ack_o && dbg_we_i && !dbg_erase_i && locked_o
        && dbg_sect_i != SECT_USER_ROW && $past(locked_o)
        && $past(locked_o, 2) |-> dbg_denied_o)
        else $error("locked write not refused");
    chk_erase_cause: assert property (
        erase_o |-> dbg_erase_i) else $error("erase without command");
    chk_erase_ack: assert property (
        erase_done_i |=> dbg_ack_o) else $error("erase not acknowledged");
    chk_cfg_hold: assert property (
        cfg_valid_o && $past(cfg_valid_o) |-> $stable({scan_region_o,
        code_blocks_o, boot_blocks_o})) else $error("config moved");
    chk_boot_whole: assert property (
        cfg_valid_o |-> boot_whole_flash_o == (boot_blocks_o == 8'h00)
        && (!boot_whole_flash_o || code_blocks_o == 8'h00))
        else $error("boot size decode wrong");
endmodule
bind fcl_guard fcl_guard_props chk (.*);
`default_nettype wire

// ---- bench/fcl_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fcl_mem_model
    import fcl_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic req_i, // access request
    input wire logic we_i, // write
    input wire logic [2:0] sect_i, // section
    input wire logic [15:0] addr_i, // address
    input wire logic [7:0] wdata_i, // write byte
    input wire logic slow_i, // answer late
    input wire logic erase_i, // erase start
    input wire logic erase_ee_i, // wipe eeprom too
    output logic ack_o, // access done
    output logic [7:0] rdata_o, // read byte
    output logic [31:0] key_o, // stored key
    output logic done_o // erase done
);
    // nonvolatile, so never cleared by reset
    logic [7:0] mem [8][16];
    logic [3:0] wait_cnt;
    logic [2:0] er_cnt;
    initial begin
        mem = '{default: 8'h00};
        {mem[6][3], mem[6][2], mem[6][1], mem[6][0]} = KEY_UNLOCK;
    end
    assign key_o = {mem[6][3], mem[6][2], mem[6][1], mem[6][0]};

    // one access at a time; read bus toggles once released
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 8'h5A;
            wait_cnt <= 4'h0;
            er_cnt <= 3'h0;
        end else begin
            ack_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (req_i && !ack_o) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= (slow_i ? 4'h5 : 4'h0)) begin
                    ack_o <= 1'b1;
                    wait_cnt <= 4'h0;
                    rdata_o <= mem[sect_i][addr_i[3:0]];
                    if (we_i) mem[sect_i][addr_i[3:0]] <= wdata_i;
                end
            end
            if (erase_i) er_cnt <= 3'h4;
            else if (er_cnt != 3'h0) begin
                er_cnt <= er_cnt - 3'h1;
                if (er_cnt == 3'h1) begin
                    done_o <= 1'b1;
                    mem[0] <= '{default: 8'h00};
                    if (erase_ee_i) mem[2] <= '{default: 8'h00};
                    mem[6][0] <= KEY_UNLOCK[7:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top
    import fcl_pkg::*;
;
    logic clk_i, sys_rst_i, slow_i, mem_req_o, mem_we_o, mem_ack_i;
    logic erase_o, erase_eeprom_o, erase_done_i, cpu_req_i, cpu_we_i;
    logic cpu_ack_o, cpu_denied_o, dbg_req_i, dbg_we_i, dbg_erase_i;
    logic dbg_ack_o, dbg_denied_o, osc_slow_o, osc_reserved_o;
    logic scan_enable_o, scan_crc32_o, rst_pin_reset_o, supply_dual_o;
    logic supply_reserved_o, boot_whole_flash_o, cfg_valid_o, locked_o;
    logic [1:0] scan_region_o;
    logic [2:0] mem_sect_o, cpu_sect_i, dbg_sect_i;
    logic [15:0] mem_addr_o, cpu_addr_i, dbg_addr_i;
    logic [7:0] mem_wdata_o, mem_rdata_i, cpu_rdata_o, dbg_rdata_o;
    logic [7:0] cpu_wdata_i, dbg_wdata_i, code_blocks_o, boot_blocks_o;
    logic [31:0] lock_key_i;
    logic [26:0] cfg_w;
    int failures = 0, cmp_count = 0, cyc = 0, base = -1, t;

    fcl_guard #(.CYC_PER_MS(4)) uut (.*);
    fcl_mem_model mdl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_i(mem_req_o), .we_i(mem_we_o), .sect_i(mem_sect_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .slow_i(slow_i),
        .erase_i(erase_o), .erase_ee_i(erase_eeprom_o), .ack_o(mem_ack_i),
        .rdata_o(mem_rdata_i), .key_o(lock_key_i), .done_o(erase_done_i));
    assign cfg_w = {osc_slow_o, osc_reserved_o, scan_region_o, scan_enable_o,
        scan_crc32_o, rst_pin_reset_o, supply_dual_o, supply_reserved_o,
        code_blocks_o, boot_blocks_o, boot_whole_flash_o, erase_eeprom_o};

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset(output int n);
        sys_rst_i = 1'b1;
        repeat (12) @(negedge clk_i);
        sys_rst_i = 1'b0;
        n = 0;
        while (!cfg_valid_o && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("cfg_valid", 1'b1, cfg_valid_o)
    endtask

    // one byte access; held until the edge after the ack
    task automatic acc(input logic d, we, input logic [2:0] s,
            input logic [15:0] a, input logic [7:0] wd, er, input logic dn);
        int n;
        n = 0;
        @(negedge clk_i);
        {cpu_we_i, cpu_sect_i, cpu_addr_i, cpu_wdata_i} = {we, s, a, wd};
        {dbg_we_i, dbg_sect_i, dbg_addr_i, dbg_wdata_i} = {we, s, a, wd};
        cpu_req_i = !d;
        dbg_req_i = d;
        while (!(d ? dbg_ack_o : cpu_ack_o) && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        if (!we) `CHK("rdata", er, d ? dbg_rdata_o : cpu_rdata_o)
        `CHK("denied", dn, d ? dbg_denied_o : cpu_denied_o)
        @(negedge clk_i);
        cpu_req_i = 1'b0;
        dbg_req_i = 1'b0;
    endtask

    // program fuses, see nothing move, reset, check decode and delay
    task automatic t_cfg(input logic [7:0] o, a, b, c, bt);
        logic [26:0] snap, e;
        snap = cfg_w;
        acc(1, 1, SECT_FUSE, {8'h00, OFS_OSC}, o, 8'h00, 0);
        acc(1, 1, SECT_FUSE, {8'h00, OFS_SYSA}, a, 8'h00, 0);
        acc(1, 1, SECT_FUSE, {8'h00, OFS_SYSB}, b, 8'h00, 0);
        acc(1, 1, SECT_FUSE, {8'h00, OFS_CODE}, c, 8'h00, 0);
        acc(1, 1, SECT_FUSE, {8'h00, OFS_BOOT}, bt, 8'h00, 0);
        `CHK("cfg_early", snap, cfg_w)
        do_reset(t);
        if (base < 0) base = t;
        e = {o[3:0] == 4'h1, o[3:0] > 4'h1, a[7:6], a[7:6] != 2'h3, a[5],
            a[3], b[4:3] == 2'h1, b[4:3] == 2'h0 || b[4:3] == 2'h3,
            (bt == 8'h00) ? 8'h00 : c, bt, bt == 8'h00, !a[0]};
        `CHK("cfg", e, cfg_w)
        `CHK("delay", (b[2:0] == 0) ? 0 : 4 << (b[2:0] - 1), t - base)
    endtask

    task automatic t_unlock;
        for (int s = 0; s < 8; s++) begin
            acc(0, 1, s[2:0], 16'h0009, 8'hA5, 8'h00, s > 3 && s < 7);
            acc(1, 0, s[2:0], 16'h0009, 8'h00,
                (s inside {4, 5, 6}) ? 8'h00 : 8'hA5, 0);
        end
        acc(1, 1, SECT_SIG_ROW, 16'h0009, 8'h3C, 8'h00, 1);
    endtask

    // one wrong key byte locks; slow memory answers meanwhile
    task automatic t_lock;
        slow_i = 1'b1;
        acc(1, 1, SECT_LOCK, 16'h0000, 8'h00, 8'h00, 0);
        `CHK("locked", 1'b1, locked_o)
        for (int s = 0; s < 8; s++) begin
            acc(1, 0, s[2:0], 16'h0009, 8'h00, READ_INVALID, 0);
            acc(1, 1, s[2:0], 16'h0009, 8'h77, 8'h00, s != 3);
        end
        acc(0, 0, SECT_USER_ROW, 16'h0009, 8'h00, 8'h77, 0);
        acc(0, 1, SECT_FLASH, 16'h0009, 8'h66, 8'h00, 0);
        acc(0, 0, SECT_FLASH, 16'h0009, 8'h00, 8'h66, 0);
        slow_i = 1'b0;
    endtask

    task automatic t_erase;
        int n;
        n = 0;
        @(negedge clk_i);
        dbg_erase_i = 1'b1;
        while (!dbg_ack_o && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        dbg_erase_i = 1'b0;
        `CHK("unlocked", 1'b0, locked_o)
        acc(1, 0, SECT_FLASH, 16'h0009, 8'h00, 8'h00, 0);
        acc(1, 0, SECT_EEPROM, 16'h0009, 8'h00, 8'h00, 0);
    endtask

    initial begin
        {slow_i, cpu_req_i, cpu_we_i, dbg_req_i, dbg_we_i, dbg_erase_i} = 6'h0;
        {cpu_sect_i, cpu_addr_i, cpu_wdata_i} = 27'h0;
        {dbg_sect_i, dbg_addr_i, dbg_wdata_i} = 27'h0;
        sys_rst_i = 1'b1;
        do_reset(t);
        t_cfg(8'h01, 8'h29, 8'h10, 8'h20, 8'h04);
        t_cfg(8'h00, 8'hC0, 8'h0A, 8'h10, 8'h00);
        t_cfg(8'h05, 8'h40, 8'h07, 8'h30, 8'h08);
        t_cfg(8'h02, 8'h80, 8'h1B, 8'hFF, 8'h01);
        t_unlock();
        t_lock();
        t_erase();
        end_of_test();
    end
endmodule
`default_nettype wire
